// [cots_pkg.sv]
package cots_pkg;

  // Object dictionary indices of the configuration records
  localparam logic [15:0] SYNC_ID_INDEX     = 16'h1015;
  localparam logic [15:0] COMM_REC_INDEX    = 16'h1800;
  localparam logic [15:0] MAP_REC_INDEX     = 16'h1a00;
  localparam logic [15:0] COMM_LAST_INDEX   = 16'h1803;

  // Reset values
  localparam logic [31:0] SYNC_ID_RESET     = 32'h0000_0080;
  localparam logic [7:0]  COMM_LAST_SUB     = 8'h05;
  localparam logic [7:0]  TTYPE_RESET       = 8'hfe;
  localparam logic [15:0] EVT_RESET         = 16'h0000;
  localparam logic [15:0] INH_RESET         = 16'h0000;
  localparam logic [2:0]  MAPCNT_RESET      = 3'h0;
  localparam logic [10:0] ID_BASE_STEP      = 11'h100;
  localparam logic [10:0] ID_BASE_FIRST     = 11'h180;

  // Transmission types
  localparam logic [7:0]  TT_ACYC_SYNC      = 8'h00;
  localparam logic [7:0]  TT_CYC_MAX        = 8'hf0;
  localparam logic [7:0]  TT_SYNC_RTR       = 8'hfc;
  localparam logic [7:0]  TT_ASYNC_RTR      = 8'hfd;
  localparam logic [7:0]  TT_TIMER          = 8'hfe;
  localparam logic [7:0]  TT_COS            = 8'hff;

  // COB-ID word fields
  localparam int          COBID_OFF_BIT     = 31;
  localparam int          COBID_ID_MSB      = 10;

  // Mapping entry fields
  localparam int          MAP_LEN_MSB       = 7;
  localparam int          MAP_MAX_OBJ       = 4;
  localparam int          MAP_MAX_BITS      = 64;

  // Tick timing
  localparam int          CLK_HZ            = 50_000_000;
  localparam int          TICK_US           = 100;
  localparam int          TICK_CYC          = CLK_HZ / 1_000_000 * TICK_US;
  localparam int          MS_PER_TICKS      = 10;
  localparam int          EVT_MIN_MS        = 2;

  // Software-side register word offsets (APB byte addresses)
  localparam logic [7:0]  A_SYNC_ID         = 8'h00;
  localparam logic [7:0]  A_CTRL            = 8'h04;
  localparam logic [7:0]  A_STATUS          = 8'h08;
  localparam logic [7:0]  A_SEL             = 8'h0c;
  localparam logic [7:0]  A_COBID           = 8'h10;
  localparam logic [7:0]  A_TTYPE           = 8'h14;
  localparam logic [7:0]  A_INHIBIT         = 8'h18;
  localparam logic [7:0]  A_EVENT           = 8'h1c;
  localparam logic [7:0]  A_MAPCNT          = 8'h20;
  localparam logic [7:0]  A_MAP0            = 8'h24;
  localparam logic [7:0]  A_TXCNT           = 8'h34;

  // Config write kinds on the link
  typedef enum logic [2:0] {
    COTS_CFG_SYNCID = 3'h0,
    COTS_CFG_COBID  = 3'h1,
    COTS_CFG_TTYPE  = 3'h2,
    COTS_CFG_INH    = 3'h3,
    COTS_CFG_EVT    = 3'h4,
    COTS_CFG_MAPCNT = 3'h5,
    COTS_CFG_MAP    = 3'h6
  } cots_cfg_t;

endpackage : cots_pkg

// [cots_if.sv]
`timescale 1ns/1ps
// Link between the PDO scheduler and the network-side controller
interface cots_if;
  import cots_pkg::*;
  logic              cfg_valid;   // Config write strobe
  cots_cfg_t         cfg_kind;    // Which object
  logic [1:0]        cfg_pdo;     // PDO number
  logic [1:0]        cfg_sub;     // Mapping entry number
  logic [31:0]       cfg_data;    // Config value
  logic              rx_valid;    // Received frame strobe
  logic [10:0]       rx_id;       // Received identifier
  logic              rx_rtr;      // Remote frame flag
  logic              operational; // Node in operational state
  logic              obj_change;  // Mapped object value changed
  logic [1:0]        obj_pdo;     // PDO whose object changed
  logic [63:0]       obj_data;    // Current object values, packed
  logic              tx_valid;    // Frame offered
  logic              tx_ready;    // Controller accepts frame
  logic [10:0]       tx_id;       // Frame identifier
  logic [3:0]        tx_len;      // Data length in bytes
  logic [63:0]       tx_data;     // Data field, byte 0 low
  logic [1:0]        tx_pdo;      // Sending PDO
  logic              sync_seen;   // SYNC accepted pulse

  modport dev (
    input  cfg_valid, cfg_kind, cfg_pdo, cfg_sub, cfg_data,
    input  rx_valid, rx_id, rx_rtr, operational,
    input  obj_change, obj_pdo, obj_data, tx_ready,
    output tx_valid, tx_id, tx_len, tx_data, tx_pdo, sync_seen
  );
  modport host (
    output cfg_valid, cfg_kind, cfg_pdo, cfg_sub, cfg_data,
    output rx_valid, rx_id, rx_rtr, operational,
    output obj_change, obj_pdo, obj_data, tx_ready,
    input  tx_valid, tx_id, tx_len, tx_data, tx_pdo, sync_seen
  );
endinterface : cots_if

// [cots_dev.sv]
`timescale 1ns/1ps
module cots_dev #(
  parameter logic [6:0] NODE_ID = 7'h01     // Node identifier
) (
  input  wire logic pclk,                   // System clock
  input  wire logic presetn,                // Async reset, low
  cots_if.dev       lnk                     // Network-side link
);
  import cots_pkg::*;

  typedef struct packed {
    logic [31:0]          cobid;
    logic [7:0]           ttype;
    logic [15:0]          inh;
    logic [15:0]          evt;
    logic [2:0]           mapcnt;
    logic [3:0][31:0]     map;
    logic [7:0]           sync_cnt;
    logic [15:0]          inh_cnt;
    logic [15:0]          evt_cnt;
    logic [3:0]           evt_sub;
    logic                 pend;
    logic                 latched;        // Snapshot held, or type 0 armed
    logic [63:0]          snap;
  } cots_pdo_t;

  typedef struct packed {
    logic [31:0]          sync_id;
    logic [3:0][$bits(cots_pdo_t)-1:0] pdo;
    logic [15:0]          tick_cnt;
    logic                 tick;
    logic                 tx_valid;
    logic [10:0]          tx_id;
    logic [3:0]           tx_len;
    logic [63:0]          tx_data;
    logic [1:0]           tx_pdo;
    logic                 sync_seen;
  } cots_dev_t;

  cots_dev_t s_r;
  cots_dev_t s_nxt;

  // Bit length of a mapping, clipped to eight bytes
  function automatic logic [6:0] map_bits(input cots_pdo_t p);
    logic [9:0] b;
    b = 10'h000;
    for (int k = 0; k < MAP_MAX_OBJ; k++)
      if (k < int'(p.mapcnt))
        b = b + {2'b00, p.map[k][MAP_LEN_MSB:0]};
    return (b > 10'(MAP_MAX_BITS)) ? 7'(MAP_MAX_BITS) : b[6:0];
  endfunction : map_bits

  // Concatenate mapped object slices in order
  function automatic logic [63:0] build(input cots_pdo_t p,
                                        input logic [63:0] v);
    logic [63:0] d;
    logic [9:0]  pos;
    logic [7:0]  len;
    d = 64'h0;
    pos = 10'h000;
    for (int k = 0; k < MAP_MAX_OBJ; k++)
    begin
      len = p.map[k][MAP_LEN_MSB:0];
      if (k < int'(p.mapcnt))
      begin
        for (int b = 0; b < MAP_MAX_BITS; b++)
          if (b < int'(len) && int'(pos) + b < MAP_MAX_BITS)
            d[int'(pos) + b] = v[int'(pos) + b];
        pos = 10'(int'(pos) + int'(len));
      end
    end
    return d;
  endfunction : build

  // Next-state logic
  always_comb
  begin
    cots_pdo_t p;
    logic      is_sync;
    logic      done;
    logic      sent;
    logic      trig;
    logic      timer_on;
    logic [15:0] evt_ms;
    p = '0;
    trig = 1'b0;
    timer_on = 1'b0;
    evt_ms = 16'h0;
    s_nxt = s_r;
    s_nxt.sync_seen = 1'b0;
    sent = 1'b0;
    done = s_r.tx_valid && lnk.tx_ready;
    if (done)
      s_nxt.tx_valid = 1'b0;
    // 100 us base tick
    s_nxt.tick = 1'b0;
    if (s_r.tick_cnt == 16'(TICK_CYC - 1))
    begin
      s_nxt.tick_cnt = 16'h0;
      s_nxt.tick = 1'b1;
    end
    else
      s_nxt.tick_cnt = s_r.tick_cnt + 16'h1;
    is_sync = lnk.rx_valid && !lnk.rx_rtr &&
              lnk.rx_id == s_r.sync_id[COBID_ID_MSB:0];
    s_nxt.sync_seen = is_sync;
    if (lnk.cfg_valid && lnk.cfg_kind == COTS_CFG_SYNCID)
      s_nxt.sync_id = lnk.cfg_data;
    for (int i = 0; i < 4; i++)
    begin
      p = s_r.pdo[i];
      trig = 1'b0;
      // Configuration writes
      if (lnk.cfg_valid && lnk.cfg_pdo == 2'(i))
        unique case (lnk.cfg_kind)
          COTS_CFG_COBID:  p.cobid = lnk.cfg_data & 32'h8000_07ff;
          COTS_CFG_TTYPE:
          begin
            // A new type drops stale snapshots; type 0 starts armed
            if (lnk.cfg_data[7:0] != p.ttype)
              p.latched = (lnk.cfg_data[7:0] == TT_ACYC_SYNC);
            p.ttype = lnk.cfg_data[7:0];
          end
          COTS_CFG_INH:    p.inh = lnk.cfg_data[15:0];
          COTS_CFG_EVT:    p.evt = lnk.cfg_data[15:0];
          COTS_CFG_MAPCNT: p.mapcnt = (lnk.cfg_data[2:0] > 3'd4) ?
                                      3'd4 : lnk.cfg_data[2:0];
          COTS_CFG_MAP:    if (p.mapcnt == 3'h0)
                             p.map[lnk.cfg_sub] = lnk.cfg_data;
          default: ;
        endcase
      // Sync-driven types
      if (is_sync)
      begin
        if (p.ttype == TT_ACYC_SYNC)
        begin
          trig = p.latched;
          p.latched = 1'b0;
        end
        else if (p.ttype <= TT_CYC_MAX)
        begin
          if (p.sync_cnt + 8'h1 >= p.ttype)
          begin
            p.sync_cnt = 8'h0;
            trig = 1'b1;
          end
          else
            p.sync_cnt = p.sync_cnt + 8'h1;
        end
        else if (p.ttype == TT_SYNC_RTR)
        begin
          p.snap = build(p, lnk.obj_data);
          p.latched = 1'b1;
        end
      end
      // Remote requests
      if (lnk.rx_valid && lnk.rx_rtr &&
          lnk.rx_id == p.cobid[COBID_ID_MSB:0])
      begin
        if (p.ttype == TT_SYNC_RTR && p.latched)
          trig = 1'b1;
        else if (p.ttype == TT_ASYNC_RTR)
          trig = 1'b1;
      end
      // Object change sends type 255, arms type 0
      if (lnk.obj_change && lnk.obj_pdo == 2'(i))
      begin
        if (p.ttype == TT_COS)
          trig = 1'b1;
        if (p.ttype == TT_ACYC_SYNC)
          p.latched = 1'b1;
      end
      // Event timer in ms, floored at 2 ms
      timer_on = (p.ttype == TT_TIMER || p.ttype == TT_COS) &&
                 p.evt != EVT_RESET;
      evt_ms = (p.evt < 16'(EVT_MIN_MS)) ? 16'(EVT_MIN_MS) : p.evt;
      if (!timer_on)
      begin
        p.evt_cnt = 16'h0;
        p.evt_sub = 4'h0;
      end
      else if (s_r.tick)
      begin
        if (p.evt_sub == 4'(MS_PER_TICKS - 1))
        begin
          p.evt_sub = 4'h0;
          if (p.evt_cnt + 16'h1 >= evt_ms)
          begin
            p.evt_cnt = 16'h0;
            trig = 1'b1;
          end
          else
            p.evt_cnt = p.evt_cnt + 16'h1;
        end
        else
          p.evt_sub = p.evt_sub + 4'h1;
      end
      // Inhibit countdown
      if (s_r.tick && p.inh_cnt != 16'h0)
        p.inh_cnt = p.inh_cnt - 16'h1;
      if (trig)
        p.pend = 1'b1;
      if (!lnk.operational || p.cobid[COBID_OFF_BIT] ||
          p.mapcnt == 3'h0)
        p.pend = 1'b0;
      // Launch one frame at a time, lowest PDO first
      if (p.pend && p.inh_cnt == 16'h0 && !sent &&
          (!s_r.tx_valid || done))
      begin
        sent = 1'b1;
        p.pend = 1'b0;
        p.inh_cnt = p.inh;
        s_nxt.tx_valid = 1'b1;
        s_nxt.tx_id = p.cobid[COBID_ID_MSB:0];
        s_nxt.tx_len = 4'(({1'b0, map_bits(p)} + 8'd7) >> 3);
        s_nxt.tx_data = (p.ttype == TT_SYNC_RTR) ? p.snap :
                        build(p, lnk.obj_data);
        s_nxt.tx_pdo = 2'(i);
      end
      s_nxt.pdo[i] = p;
    end
  end

  // State register with default identifiers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.sync_id <= SYNC_ID_RESET;
      for (int i = 0; i < 4; i++)
      begin
        s_r.pdo[i][$bits(cots_pdo_t)-1 -: 32] <=
          {21'h0, 11'(ID_BASE_FIRST + ID_BASE_STEP * 11'(i)) |
           {4'h0, NODE_ID}};
        s_r.pdo[i][$bits(cots_pdo_t)-33 -: 8] <= TTYPE_RESET;
      end
    end
    else
      s_r <= s_nxt;
  end

  assign lnk.tx_valid  = s_r.tx_valid;
  assign lnk.tx_id     = s_r.tx_id;
  assign lnk.tx_len    = s_r.tx_len;
  assign lnk.tx_data   = s_r.tx_data;
  assign lnk.tx_pdo    = s_r.tx_pdo;
  assign lnk.sync_seen = s_r.sync_seen;
endmodule : cots_dev

// [cots_host.sv]
`timescale 1ns/1ps
// Network-side end: APB registers drive config, frames, object values
module cots_host (
  input  wire logic        pclk,     // System clock
  input  wire logic        presetn,  // Async reset, low
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB enable
  input  wire logic        pwrite,   // APB direction
  input  wire logic [7:0]  paddr,    // APB address
  input  wire logic [31:0] pwdata,   // APB write data
  output logic      [31:0] prdata,   // APB read data
  output logic             pready,   // APB ready
  output logic             pslverr,  // APB error
  cots_if.host             lnk       // Device link
);
  import cots_pkg::*;

  typedef struct packed {
    logic        cfg_valid;
    cots_cfg_t   cfg_kind;
    logic [1:0]  cfg_pdo;
    logic [1:0]  cfg_sub;
    logic [31:0] cfg_data;
    logic        rx_valid;
    logic [10:0] rx_id;
    logic        rx_rtr;
    logic        oper;
    logic        chg;
    logic [1:0]  chg_pdo;
    logic [63:0] obj;
    logic        tx_ready;
    logic [1:0]  sel;
    logic [15:0] txcnt;
    logic [10:0] last_id;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } cots_host_t;

  cots_host_t s_r;
  cots_host_t s_nxt;
  logic       acc;

  assign acc = psel && penable && !s_r.ready;

  // Register decode; ctrl: [0] oper [1] rx frame [2] rtr [3] change
  // [4] tx_ready, [26:16] rx id, [29:28] change pdo
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.cfg_valid = 1'b0;
    s_nxt.rx_valid = 1'b0;
    s_nxt.chg = 1'b0;
    s_nxt.ready = acc;
    s_nxt.err = 1'b0;
    s_nxt.rdata = 32'h0;
    if (lnk.tx_valid && s_r.tx_ready)
    begin
      s_nxt.txcnt = s_r.txcnt + 16'h1;
      s_nxt.last_id = lnk.tx_id;
    end
    if (acc && pwrite)
    begin
      s_nxt.cfg_pdo = s_r.sel;
      s_nxt.cfg_data = pwdata;
      s_nxt.cfg_valid = 1'b1;
      unique case (paddr)
        A_SYNC_ID: s_nxt.cfg_kind = COTS_CFG_SYNCID;
        A_COBID:   s_nxt.cfg_kind = COTS_CFG_COBID;
        A_TTYPE:   s_nxt.cfg_kind = COTS_CFG_TTYPE;
        A_INHIBIT: s_nxt.cfg_kind = COTS_CFG_INH;
        A_EVENT:   s_nxt.cfg_kind = COTS_CFG_EVT;
        A_MAPCNT:  s_nxt.cfg_kind = COTS_CFG_MAPCNT;
        A_SEL:
        begin
          s_nxt.sel = pwdata[1:0];
          s_nxt.cfg_valid = 1'b0;
        end
        A_CTRL:
        begin
          s_nxt.cfg_valid = 1'b0;
          s_nxt.oper = pwdata[0];
          s_nxt.rx_valid = pwdata[1];
          s_nxt.rx_rtr = pwdata[2];
          s_nxt.chg = pwdata[3];
          s_nxt.tx_ready = pwdata[4];
          s_nxt.rx_id = pwdata[26:16];
          s_nxt.chg_pdo = pwdata[29:28];
        end
        A_TXCNT:
        begin
          s_nxt.cfg_valid = 1'b0;
          s_nxt.obj[31:0] = pwdata;
        end
        A_STATUS:
        begin
          s_nxt.cfg_valid = 1'b0;
          s_nxt.obj[63:32] = pwdata;
        end
        default:
        begin
          s_nxt.cfg_valid = 1'b0;
          if (paddr >= A_MAP0 && paddr < A_TXCNT && paddr[1:0] == 2'h0)
          begin
            s_nxt.cfg_kind = COTS_CFG_MAP;
            s_nxt.cfg_sub = 2'(paddr[3:2] - A_MAP0[3:2]);
            s_nxt.cfg_valid = 1'b1;
          end
          else
            s_nxt.err = 1'b1;
        end
      endcase
    end
    else if (acc)
      unique case (paddr)
        A_TXCNT:  s_nxt.rdata = {16'h0, s_r.txcnt};
        A_STATUS: s_nxt.rdata = {20'h0, s_r.last_id, lnk.tx_valid};
        A_CTRL:   s_nxt.rdata = {2'h0, s_r.chg_pdo, 1'b0, s_r.rx_id,
                                 11'h0, s_r.tx_ready, 3'h0, s_r.oper};
        A_SEL:    s_nxt.rdata = {30'h0, s_r.sel};
        default:  s_nxt.rdata = 32'h0;
      endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign prdata          = s_r.rdata;
  assign pready          = s_r.ready;
  assign pslverr         = s_r.err;
  assign lnk.cfg_valid   = s_r.cfg_valid;
  assign lnk.cfg_kind    = s_r.cfg_kind;
  assign lnk.cfg_pdo     = s_r.cfg_pdo;
  assign lnk.cfg_sub     = s_r.cfg_sub;
  assign lnk.cfg_data    = s_r.cfg_data;
  assign lnk.rx_valid    = s_r.rx_valid;
  assign lnk.rx_id       = s_r.rx_id;
  assign lnk.rx_rtr      = s_r.rx_rtr;
  assign lnk.operational = s_r.oper;
  assign lnk.obj_change  = s_r.chg;
  assign lnk.obj_pdo     = s_r.chg_pdo;
  assign lnk.obj_data    = s_r.obj;
  assign lnk.tx_ready    = s_r.tx_ready;
endmodule : cots_host

// [cots_sva.sv]
`timescale 1ns/1ps
// Link watcher between the scheduler and the network-side end
module cots_sva #(
  parameter logic [6:0] NODE_ID = 7'h01  // Node identifier
) (
  input wire logic               pclk,        // System clock
  input wire logic               presetn,     // Async reset, low
  input wire logic               cfg_valid,   // Config strobe
  input wire cots_pkg::cots_cfg_t cfg_kind,   // Config object
  input wire logic [1:0]         cfg_pdo,     // Config PDO
  input wire logic [31:0]        cfg_data,    // Config value
  input wire logic               rx_valid,    // Frame received
  input wire logic [10:0]        rx_id,       // Received identifier
  input wire logic               rx_rtr,      // Remote flag
  input wire logic               operational, // Operational state
  input wire logic               tx_valid,    // Frame offered
  input wire logic               tx_ready,    // Frame accepted
  input wire logic [10:0]        tx_id,       // Frame identifier
  input wire logic [3:0]         tx_len,      // Frame length
  input wire logic [63:0]        tx_data,     // Frame data
  input wire logic [1:0]         tx_pdo,      // Sending PDO
  input wire logic               sync_seen    // SYNC pulse
);
  import cots_pkg::*;
  logic [31:0] cob_r [4];
  logic [7:0]  tt_r [4];
  logic [2:0]  mc_r [4];
  logic        inh0_r;
  logic [10:0] sid_r;
  logic        pdo0_free;

  // Shadow of the configuration sent over the link
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      for (int p = 0; p < 4; p++)
      begin
        cob_r[p] <= {21'h0, (ID_BASE_FIRST + ID_BASE_STEP * 11'(p))
                     | {4'h0, NODE_ID}};
        tt_r[p] <= TTYPE_RESET;
        mc_r[p] <= MAPCNT_RESET;
      end
      inh0_r <= (INH_RESET == 16'h0);
      sid_r <= SYNC_ID_RESET[10:0];
    end
    else if (cfg_valid)
      case (cfg_kind)
        COTS_CFG_SYNCID: sid_r <= cfg_data[10:0];
        COTS_CFG_COBID:  cob_r[cfg_pdo] <= cfg_data;
        COTS_CFG_TTYPE:  tt_r[cfg_pdo] <= cfg_data[7:0];
        COTS_CFG_MAPCNT: mc_r[cfg_pdo] <= cfg_data[2:0];
        COTS_CFG_INH:    if (cfg_pdo == 2'd0) inh0_r <= cfg_data[15:0] == 0;
        default: ;
      endcase

  // PDO 0 able to go out on the next edge
  assign pdo0_free = operational && mc_r[0] != 3'h0 && !cob_r[0][31]
                     && inh0_r && !tx_valid;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence sync_rx;
    rx_valid && !rx_rtr && rx_id == sid_r;
  endsequence
  sequence rtr0_rx;
    rx_valid && rx_rtr && rx_id == cob_r[0][10:0];
  endsequence

  sync_pulse_a: assert property (sync_rx |=> sync_seen)
    else $error("SYNC pulse missing");
  sync_cause_a: assert property (sync_seen |->
    $past(rx_valid && !rx_rtr && rx_id == sid_r))
    else $error("SYNC pulse without SYNC frame");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid
    && $stable(tx_id) && $stable(tx_data) && $stable(tx_len))
    else $error("Offered frame changed before acceptance");
  tx_ident_a: assert property (tx_valid |->
    tx_id == cob_r[tx_pdo][10:0] && !cob_r[tx_pdo][31])
    else $error("Frame identifier wrong or PDO disabled");
  tx_len_a: assert property (tx_valid |-> tx_len <= 4'd8)
    else $error("Frame longer than eight bytes");
  map_empty_a: assert property (tx_valid |-> mc_r[tx_pdo] != 3'h0)
    else $error("Frame from PDO with no mapping");
  op_only_a: assert property ($rose(tx_valid) |-> operational)
    else $error("Frame offered outside operational state");
  cyc_one_a: assert property ((tt_r[0] == 8'h01 && pdo0_free)
    ##0 sync_rx |=> tx_valid && tx_pdo == 2'd0)
    else $error("Type 1 PDO not sent on SYNC");
  rtr_async_a: assert property ((tt_r[0] == TT_ASYNC_RTR && pdo0_free)
    ##0 rtr0_rx |=> tx_valid && tx_pdo == 2'd0)
    else $error("Type 253 PDO not sent on remote frame");
  sync_quiet_a: assert property ((tt_r[0] == TT_SYNC_RTR && pdo0_free)
    ##0 sync_rx |=> !tx_valid)
    else $error("Type 252 PDO sent on SYNC");
endmodule : cots_sva

// [canopen_tpdo_scheduler_test.sv]
`timescale 1ns/1ps
// Random and corner traffic through APB, frames watched on the link
module canopen_tpdo_scheduler_test;
  import cots_pkg::*;
  localparam logic [6:0] NODE  = 7'h05;
  localparam int         LIMIT = 20000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        serr, op, rdy;
  logic [10:0] cob, sid, fid, e11;
  logic [3:0]  flen;
  logic [63:0] fdat, cur, prv, m;
  int          errors, checks, nfr, nn, cyc, seed, bits, n, nsy, ns0;

  cots_if lnk ();
  cots_dev #(.NODE_ID(NODE)) i_cots_dev (.pclk(pclk), .presetn(presetn),
    .lnk(lnk));
  cots_host i_cots_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
  cots_sva #(.NODE_ID(NODE)) i_cots_sva (.pclk(pclk), .presetn(presetn),
    .cfg_valid(lnk.cfg_valid), .cfg_kind(lnk.cfg_kind),
    .cfg_pdo(lnk.cfg_pdo), .cfg_data(lnk.cfg_data),
    .rx_valid(lnk.rx_valid), .rx_id(lnk.rx_id), .rx_rtr(lnk.rx_rtr),
    .operational(lnk.operational), .tx_valid(lnk.tx_valid),
    .tx_ready(lnk.tx_ready), .tx_id(lnk.tx_id), .tx_len(lnk.tx_len),
    .tx_data(lnk.tx_data), .tx_pdo(lnk.tx_pdo), .sync_seen(lnk.sync_seen));

  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Frame capture and hang limit
  always @(posedge pclk)
  begin
    cyc++;
    if (lnk.sync_seen === 1'b1)
      nsy++;
    if (lnk.tx_valid === 1'b1 && lnk.tx_ready === 1'b1)
    begin
      nfr++;
      fid = lnk.tx_id;
      flen = lnk.tx_len;
      fdat = lnk.tx_data;
    end
    if (cyc == LIMIT)
    begin
      errors++;
      end_of_test();
    end
  end

  // Compare and count
  task chk(input string what, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // One APB transfer, waits for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Control word: strobes {change, remote, receive}
  function logic [31:0] ctl(input logic [2:0] k, input logic [10:0] id);
    logic [31:0] w;
    w = 32'h0;
    w[0] = op;
    w[4] = rdy;
    w[3:1] = k;
    w[26:16] = id;
    return w;
  endfunction : ctl

  // Refresh objects, set type, send triggers, count frames
  task run(input logic [7:0] tt, input int ns, nr, nc, ex);
    nn = nfr;
    prv = cur;
    cur = {$random(seed), $random(seed)};
    apb(1'b1, A_TXCNT, cur[31:0]);
    apb(1'b1, A_STATUS, cur[63:32]);
    apb(1'b1, A_TTYPE, {24'h0, tt});
    repeat (ns) apb(1'b1, A_CTRL, ctl(3'b001, sid));
    repeat (nr) apb(1'b1, A_CTRL, ctl(3'b011, cob));
    repeat (nc) apb(1'b1, A_CTRL, ctl(3'b100, 11'h0));
    repeat (8) @(posedge pclk);
    chk("frames", ex, nfr - nn);
    if (ex > 0)
    begin
      chk("id", cob, fid);
      chk("len", bits / 8, flen);
      chk("data", ((tt == TT_SYNC_RTR) ? prv : cur) & m, fdat & m);
    end
  endtask : run

  // Verdict
  task end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // Main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {errors, checks, nfr, cyc, nsy} = '0;
    seed = 32'hb9cb;
    presetn = 1'b0;
    op = 1'b0;
    rdy = 1'b1;
    sid = SYNC_ID_RESET[10:0];
    cob = ID_BASE_FIRST | {4'h0, NODE};
    cur = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Reset defaults seen through traffic of each PDO
    op = 1'b1;
    for (int p = 0; p < 4; p++)
    begin
      e11 = (ID_BASE_FIRST + ID_BASE_STEP * 11'(p)) | {4'h0, NODE};
      nn = nfr;
      ns0 = nsy;
      apb(1'b1, A_SEL, p);
      apb(1'b1, A_MAPCNT, 32'h1);
      apb(1'b1, A_CTRL, ctl(3'b011, e11));
      apb(1'b1, A_CTRL, ctl(3'b001, sid));
      repeat (2) @(posedge pclk);
      chk("ttype", 0, nfr - nn);
      chk("sync id", 1, nsy - ns0);
      apb(1'b1, A_TTYPE, {24'h0, TT_ASYNC_RTR});
      apb(1'b1, A_MAPCNT, 32'h0);
      apb(1'b1, A_CTRL, ctl(3'b011, e11));
      repeat (2) @(posedge pclk);
      chk("map count", 0, nfr - nn);
      apb(1'b1, A_MAPCNT, 32'h1);
      apb(1'b1, A_CTRL, ctl(3'b011, e11));
      apb(1'b1, A_MAPCNT, 32'h0);
      chk("frames", 1, nfr - nn);
      chk("cobid", {21'h0, e11}, fid);
    end
    apb(1'b1, 8'h3c, 32'h5);
    chk("slverr", 1, serr);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped", 0, rd);
    // Map two objects of random size on PDO 0
    apb(1'b1, A_SEL, 32'h0);
    n = 8 + 8 * ($unsigned($random(seed)) % 3);
    bits = 8 + 8 * ($unsigned($random(seed)) % 3);
    apb(1'b1, A_MAPCNT, 32'h0);
    apb(1'b1, A_MAP0, 32'h2000_0000 | n);
    apb(1'b1, A_MAP0 + 8'h04, 32'h2001_0000 | bits);
    apb(1'b1, A_MAPCNT, 32'h2);
    bits = bits + n;
    m = (64'h1 << bits) - 64'h1;
    op = 1'b1;
    apb(1'b1, A_CTRL, ctl(3'b000, 11'h0));
    run(8'd1, 2, 0, 0, 2);
    n = 1 + ($unsigned($random(seed)) % 4);
    run(n[7:0], 3 * n, 0, 0, 3);
    run(TT_ACYC_SYNC, 2, 0, 0, 1);
    run(TT_SYNC_RTR, 2, 0, 0, 0);
    run(TT_SYNC_RTR, 0, 1, 0, 1);
    run(TT_ASYNC_RTR, 1, 1, 0, 1);
    run(TT_COS, 0, 0, 2, 2);
    run(TT_TIMER, 1, 1, 1, 0);
    sid = 11'h0a5;
    apb(1'b1, A_SYNC_ID, {21'h0, sid});
    run(8'd1, 2, 0, 0, 2);
    cob = 11'h200 | 11'($unsigned($random(seed)) % 256);
    apb(1'b1, A_COBID, {21'h0, cob});
    run(TT_ASYNC_RTR, 0, 1, 0, 1);
    apb(1'b1, A_COBID, {1'b1, 20'h0, cob});
    run(TT_ASYNC_RTR, 0, 1, 0, 0);
    apb(1'b1, A_COBID, {21'h0, cob});
    apb(1'b1, A_MAPCNT, 32'h0);
    run(8'd1, 1, 0, 0, 0);
    apb(1'b1, A_MAPCNT, 32'h2);
    op = 1'b0;
    run(8'd1, 1, 0, 0, 0);
    op = 1'b1;
    rdy = 1'b0;
    run(TT_ASYNC_RTR, 0, 1, 0, 0);
    apb(1'b0, A_STATUS, 32'h0);
    chk("held", 1, rd[0]);
    rdy = 1'b1;
    apb(1'b1, A_CTRL, ctl(3'b000, 11'h0));
    repeat (4) @(posedge pclk);
    chk("released", 1, nfr - nn);
    apb(1'b1, A_INHIBIT, 32'h2);
    run(TT_COS, 0, 0, 2, 1);
    repeat (10200) @(posedge pclk);
    chk("late frame", 2, nfr - nn);
    end_of_test();
  end
endmodule : canopen_tpdo_scheduler_test
